// file: egcs_top.sv
// Purpose: event generation and cam switch of one counter block
// Assumes: pclk 250 MHz; field pins asynchronous to pclk
// Notes:   narrow variant gives events, wide variant gives cam switch
//
// Notes on behaviour
// - at most two event outputs per block
// - event generation only in narrow variant
// - each path selects rise or high detection
// - rise on channel one gives one pulse
// - level mode follows channel two high/low
// - cam switch only in wide variant
// - steps below step count enabled only
// - initial level below first threshold
// - step state holds until next threshold
// - output inverts at each enabled threshold
// - count up by one per up pulse
// - separate add and subtract pulses
// - last step holds up to upper limit
`include "egcs_consts.svh"

module egcs_top
  import egcs_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // field inputs
  input  wire logic        ph_a_pin,
  input  wire logic        ph_b_pin,
  // event and cam outputs
  output logic             event0,
  output logic             event2,
  output logic             cam_out,
  output logic             irq
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sa_reg;            // phase a pipeline
  logic [2:0] sb_reg;            // phase b pipeline
  egcs_in_s   in_reg;            // debounced stable level
  egcs_in_s   in_q;              // previous stable level

  // a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_reg <= 3'h0;
      sb_reg <= 3'h0;
      in_reg <= '0;
      in_q   <= '0;
    end else if (clk_en) begin
      sa_reg <= {sa_reg[1:0], ph_a_pin};
      sb_reg <= {sb_reg[1:0], ph_b_pin};
      if (sa_reg[1] == sa_reg[2]) begin
        in_reg.ph_a <= sa_reg[2];
      end
      if (sb_reg[1] == sb_reg[2]) begin
        in_reg.ph_b <= sb_reg[2];
      end
      in_q <= in_reg;
    end
  end

  wire logic rise_a = in_reg.ph_a & ~in_q.ph_a;
  wire logic fall_a = ~in_reg.ph_a & in_q.ph_a;
  wire logic rise_b = in_reg.ph_b & ~in_q.ph_b;
  wire logic fall_b = ~in_reg.ph_b & in_q.ph_b;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0]  ctrl_reg;         // enable, ring mode, wide variant
  logic [3:0]  detsel_reg;       // [1:0] path a, [3:2] path b
  logic [3:0]  nstep_reg;        // enabled_step_count
  logic        init_lvl_reg;     // level below step 0
  logic [31:0] upper_reg;        // upper count limit
  logic [31:0] lower_reg;        // lower count limit
  logic [31:0] count_reg;        // current count
  logic [2:0]  status_reg;       // sticky: ev0, ev2, cam toggle
  logic [2:0]  mask_reg;         // interrupt enables
  logic [31:0] step_reg [`EGCS_NSTEPS]; // step thresholds

  wire logic wide = ctrl_reg[`EGCS_CTRL_WIDE];
  wire logic acc  = psel & penable;
  wire logic wr   = acc & pwrite;
  wire logic [9:0] widx = paddr[11:2];
  wire logic cnt_wr = wr && paddr == `EGCS_OFF_COUNT;

  // software configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= 3'h0;
      detsel_reg   <= 4'h0;
      nstep_reg    <= 4'h0;
      init_lvl_reg <= 1'b0;
      upper_reg    <= `EGCS_RST_UPPER;
      lower_reg    <= `EGCS_RST_LOWER;
      mask_reg     <= 3'h0;
    end else if (clk_en && wr) begin
      unique case (paddr)
        `EGCS_OFF_CTRL:    ctrl_reg   <= pwdata[2:0];
        `EGCS_OFF_DETSEL:  detsel_reg <= pwdata[3:0];
        `EGCS_OFF_CAMCFG: begin
          // counts above seven are clipped to all steps
          nstep_reg    <= (pwdata[3:0] > 4'h7) ? 4'h7 : pwdata[3:0];
          init_lvl_reg <= pwdata[8];
        end
        `EGCS_OFF_UPPER:   upper_reg  <= pwdata;
        `EGCS_OFF_LOWER:   lower_reg  <= pwdata;
        `EGCS_OFF_IRQMASK: mask_reg   <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // step threshold array, one word each
  genvar gi;
  generate
    for (gi = 0; gi < `EGCS_NSTEPS; gi++) begin : g_step
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          step_reg[gi] <= 32'h0;
        end else if (clk_en && wr &&
                     widx == 10'(`EGCS_OFF_STEP0 / 4 + gi)) begin
          step_reg[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // event generation (narrow variant only)
  // ---------------------------------------------------------------
  // only two outputs exist; chaining blocks gives more
  function automatic logic det_hit(input logic [1:0] sel,
                                   input logic lvl, input logic r);
    unique case (egcs_det_e'(sel))
      EGCS_DET_RISE: det_hit = r;
      EGCS_DET_HIGH: det_hit = lvl;
      default:       det_hit = 1'b0;
    endcase
  endfunction : det_hit

  wire logic ev0_next = ~wide & ctrl_reg[`EGCS_CTRL_EN] &
                        det_hit(detsel_reg[1:0], in_reg.ph_a, rise_a);
  wire logic ev2_next = ~wide & ctrl_reg[`EGCS_CTRL_EN] &
                        det_hit(detsel_reg[3:2], in_reg.ph_b, rise_b);

  // event outputs registered from the detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event0 <= 1'b0;
      event2 <= 1'b0;
    end else if (clk_en) begin
      event0 <= ev0_next;
      event2 <= ev2_next;
    end
  end

  // ---------------------------------------------------------------
  // up/down counter (wide variant, cam switch)
  // ---------------------------------------------------------------
  // phase a rise adds, phase b rise subtracts; both cancel
  wire logic up_p = wide & ctrl_reg[`EGCS_CTRL_EN] & rise_a & ~rise_b;
  wire logic dn_p = wide & ctrl_reg[`EGCS_CTRL_EN] & rise_b & ~rise_a;
  wire logic ring = ctrl_reg[`EGCS_CTRL_RING];

  // linear mode clamps at the limits instead of wrapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 32'h0;
    end else if (clk_en) begin
      if (cnt_wr) begin
        count_reg <= pwdata;
      end else if (up_p) begin
        if (count_reg >= upper_reg) begin
          count_reg <= ring ? lower_reg : upper_reg;
        end else begin
          count_reg <= count_reg + 32'h1;
        end
      end else if (dn_p) begin
        if (count_reg <= lower_reg) begin
          count_reg <= ring ? upper_reg : lower_reg;
        end else begin
          count_reg <= count_reg - 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // cam output: parity of thresholds passed
  // ---------------------------------------------------------------
  // derived from count, so counting back restores state
  logic cam_next;
  always_comb begin
    cam_next = init_lvl_reg;
    for (int i = 0; i < `EGCS_NSTEPS; i++) begin
      if (4'(i) < nstep_reg && count_reg >= step_reg[i]) begin
        cam_next = ~cam_next;
      end
    end
  end

  // cam output only in wide variant; last step holds to limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cam_out <= 1'b0;
    end else if (clk_en) begin
      cam_out <= wide ? cam_next : 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, write one to clear; set beats clear
  // ---------------------------------------------------------------
  wire logic [2:0] ev_set = {wide & (cam_next ^ cam_out),
                             ev2_next & ~event2, ev0_next & ~event0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 3'h0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      if (wr && paddr == `EGCS_OFF_STATUS) begin
        status_reg <= (status_reg & ~pwdata[2:0]) | ev_set;
      end else begin
        status_reg <= status_reg | ev_set;
      end
      irq <= |(status_reg & mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // apb read path; zero wait, unmapped reads zero and errors
  // ---------------------------------------------------------------
  logic [31:0] rd_next;
  logic        map_hit;
  always_comb begin
    rd_next = 32'h0;
    map_hit = 1'b1;
    unique case (paddr)
      `EGCS_OFF_CTRL:    rd_next = {29'h0, ctrl_reg};
      `EGCS_OFF_DETSEL:  rd_next = {28'h0, detsel_reg};
      `EGCS_OFF_CAMCFG:  rd_next = {23'h0, init_lvl_reg, 4'h0, nstep_reg};
      `EGCS_OFF_UPPER:   rd_next = upper_reg;
      `EGCS_OFF_LOWER:   rd_next = lower_reg;
      `EGCS_OFF_COUNT:   rd_next = count_reg;
      `EGCS_OFF_STATUS:  rd_next = {29'h0, status_reg};
      `EGCS_OFF_IRQMASK: rd_next = {29'h0, mask_reg};
      default: begin
        map_hit = (widx >= 10'(`EGCS_OFF_STEP0 / 4)) &&
                  (widx < 10'(`EGCS_OFF_STEP0 / 4 + `EGCS_NSTEPS));
        if (map_hit) begin
          rd_next = step_reg[3'(widx - 10'(`EGCS_OFF_STEP0 / 4))];
        end
      end
    endcase
  end

  // answer is registered: pready rises as the access phase begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ev0_pulse: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && event0 && detsel_reg[1:0] == 2'h1 |=> !event0)
    else $error("event0 held high in rise mode");
  a_ev2_follow: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && !wide && ctrl_reg[0] && detsel_reg[3:2] == 2'h2 |=>
    event2 == $past(in_reg.ph_b))
    else $error("event2 does not follow phase b");
  a_narrow_nocam: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && !wide |=> !cam_out)
    else $error("cam output active in narrow mode");
  a_wide_noev: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && wide |=> !event0 && !event2)
    else $error("event active in wide mode");
  a_cnt_up: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && up_p && !cnt_wr && count_reg < upper_reg |=>
    count_reg == $past(count_reg) + 32'h1)
    else $error("count did not add one");
  a_cnt_dn: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && dn_p && !cnt_wr && count_reg > lower_reg |=>
    count_reg == $past(count_reg) - 32'h1)
    else $error("count did not subtract one");
  a_ring_wrap: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && up_p && !cnt_wr && ring && count_reg >= upper_reg |=>
    count_reg == $past(lower_reg))
    else $error("ring wrap failed");
  a_init_lvl: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && wide && (nstep_reg == 4'h0 || count_reg < step_reg[0]) &&
    step_reg[0] <= step_reg[1] |=> cam_out == $past(init_lvl_reg))
    else $error("initial level wrong");
  a_cam_toggle: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && wide && nstep_reg != 4'h0 && step_reg[0] != 32'h0 &&
    step_reg[1] > step_reg[0] + 32'h1 && count_reg == step_reg[0] - 32'h1
    ##1 clk_en && count_reg == step_reg[0] |=> cam_out != $past(cam_out))
    else $error("cam output did not invert at step");
  // further guards on the event path and the counter limits
  a_ev0_rise: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && !wide && ctrl_reg[`EGCS_CTRL_EN] && detsel_reg[1:0] == 2'h1 &&
    rise_a |=> event0)
    else $error("event0 missed a rise of phase a");
  a_ev0_off: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && detsel_reg[1:0] == 2'h0 |=> !event0)
    else $error("event0 active with its path off");
  a_cnt_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && !up_p && !dn_p && !cnt_wr |=> $stable(count_reg))
    else $error("count moved without a pulse");
  a_ring_down: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && dn_p && !cnt_wr && ring && count_reg <= lower_reg |=>
    count_reg == $past(upper_reg))
    else $error("ring wrap downward failed");
  a_lin_clamp: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && up_p && !cnt_wr && !ring && count_reg >= upper_reg |=>
    count_reg == $past(upper_reg))
    else $error("linear count passed the upper limit");

endmodule : egcs_top

// file: egcs_consts.svh
// Purpose: constants for the event generator / cam switch block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   offsets, field positions and reset values only
`ifndef EGCS_CONSTS_SVH
`define EGCS_CONSTS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define EGCS_OFF_CTRL    12'h000
`define EGCS_OFF_DETSEL  12'h004
`define EGCS_OFF_CAMCFG  12'h008
`define EGCS_OFF_UPPER   12'h00c
`define EGCS_OFF_LOWER   12'h010
`define EGCS_OFF_COUNT   12'h014
`define EGCS_OFF_STATUS  12'h018
`define EGCS_OFF_IRQMASK 12'h01c
`define EGCS_OFF_STEP0   12'h020
// ---------------------------------------------------------------
// field positions and sizes
// ---------------------------------------------------------------
`define EGCS_CTRL_EN     0
`define EGCS_CTRL_RING   1
`define EGCS_CTRL_WIDE   2
`define EGCS_NSTEPS      7
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define EGCS_RST_UPPER   32'hffffffff
`define EGCS_RST_LOWER   32'h00000000
`endif

// file: egcs_pkg.sv
// Purpose: types shared by the event generator / cam switch block
// Assumes: nothing
// Notes:   detection modes per event path
package egcs_pkg;
  // detection condition of one event path
  typedef enum logic [1:0] {
    EGCS_DET_OFF,
    EGCS_DET_RISE,
    EGCS_DET_HIGH,
    EGCS_DET_FALL
  } egcs_det_e;
  // synchronised field inputs
  typedef struct packed {
    logic ph_a;
    logic ph_b;
  } egcs_in_s;
endpackage : egcs_pkg

// file: egcs_field_model.sv
// Purpose: field side model driving the two phase input pins
// Assumes: pins sampled through a synchroniser inside the block
// Notes:   pulses are held several cycles so none is lost
// ---------------------------------------------------------------
// field pin driver
// ---------------------------------------------------------------
module egcs_field_model (
  // clock
  input  wire logic pclk,
  // field pins
  output logic      ph_a_pin,
  output logic      ph_b_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle low, the level a released input rests at
  initial begin
    ph_a_pin = 1'b0;
    ph_b_pin = 1'b0;
  end

  // one pulse on a pin; width kept at or above the sync depth
  task automatic pulse(input bit which, input int hi, input int lo);
    int hw; // high width, never shorter than three cycles
    hw = (hi < 3) ? 3 : hi;
    @(posedge pclk);
    if (which) ph_b_pin <= 1'b1;
    else ph_a_pin <= 1'b1;
    repeat (hw) @(posedge pclk);
    if (which) ph_b_pin <= 1'b0;
    else ph_a_pin <= 1'b0;
    repeat (lo + 3) @(posedge pclk);
  endtask : pulse

  // hold phase b at a level, for level detection
  task automatic set_b(input logic v);
    @(posedge pclk);
    ph_b_pin <= v;
  endtask : set_b
endmodule : egcs_field_model

// file: event_gen_cam_switch_test.sv
// Purpose: self-checking bench of the event and cam switch block
// Assumes: apb answers within the bounded wait
// Notes:   count and cam level come from an integer model
`include "egcs_consts.svh"
module event_gen_cam_switch_test;
  import egcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk    = 1'b0; // 250 MHz clock
  logic        presetn = 1'b0; // reset, active low
  logic        clk_en  = 1'b1; // clock enable, low freezes the block
  logic        psel    = 1'b0; // apb select
  logic        penable = 1'b0; // apb enable
  logic        pwrite  = 1'b0; // apb direction
  logic [11:0] paddr   = 12'h000; // apb address
  logic [31:0] pwdata  = 32'h0; // apb write data
  logic [31:0] prdata, rd; // read data, captured copy
  logic        pready, pslverr, err; // answer, captured error
  logic        ph_a_pin, ph_b_pin, event0, event2, cam_out, irq;
  int          n_fail = 0, checks_done = 0; // verdict counters
  int          seed = 32'h3b76; // fixed random seed
  int          cnt, exp_cam, hw; // count model and helpers
  bit          dn; // direction of the next pulse

  always #2 pclk = ~pclk;

  // clock enable driven by the bench so the freeze can be checked
  egcs_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ph_a_pin(ph_a_pin), .ph_b_pin(ph_b_pin),
    .event0(event0), .event2(event2), .cam_out(cam_out), .irq(irq));
  egcs_field_model fld (.pclk(pclk), .ph_a_pin(ph_a_pin),
    .ph_b_pin(ph_b_pin));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // compare seen against expected, report at once
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input bit w, input logic [11:0] a,
                     input logic [31:0] d);
    int n; // bounded wait for the answer
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin n_fail++; tally_and_finish(); end
    end while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // wait for an event output to take a level, bounded
  task automatic wait_ev(input bit which, input logic v);
    int n; // cycles waited
    n = 0;
    while (((which ? event2 : event0) !== v) && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin n_fail++; tally_and_finish(); end
  endtask : wait_ev
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `EGCS_OFF_UPPER, 0); chk(rd, `EGCS_RST_UPPER);
    apb(0, `EGCS_OFF_LOWER, 0); chk(rd, `EGCS_RST_LOWER);
    apb(0, 12'h0fc, 0); chk(rd, 32'h0); // unmapped reads zero
    chk(32'(err), 32'h1); // unmapped refused
    // narrow variant: a rise, b high, irq on event0 only
    apb(1, `EGCS_OFF_CTRL, 32'h1);
    apb(1, `EGCS_OFF_DETSEL, 32'h9);
    apb(1, `EGCS_OFF_IRQMASK, 32'h1);
    fork fld.pulse(0, 6, 0); join_none
    wait_ev(0, 1'b1);
    @(posedge pclk); #1 chk(event0, 1'b0);
    repeat (3) @(posedge pclk); #1 chk(irq, 1'b1);
    apb(1, `EGCS_OFF_STATUS, 32'h1);
    repeat (3) @(posedge pclk); #1 chk(irq, 1'b0);
    fld.set_b(1'b1); wait_ev(1, 1'b1);
    repeat (6) @(posedge pclk); #1 chk(event2, 1'b1);
    chk(irq, 1'b0); // masked status bit keeps irq low
    fld.set_b(1'b0); wait_ev(1, 1'b0);
    apb(1, `EGCS_OFF_DETSEL, 32'h0); // path off
    fld.pulse(0, 6, 6); #1 chk(event0, 1'b0);
    // sticky status: no event0 rise with path off, event2 rise kept
    apb(0, `EGCS_OFF_STATUS, 0); chk(rd, 32'h2);
    // wide variant: ring 0..10, steps 2,4,6 active, 8 to 14 ignored
    apb(1, `EGCS_OFF_DETSEL, 32'h9);
    apb(1, `EGCS_OFF_CTRL, 32'h7);
    apb(1, `EGCS_OFF_UPPER, 32'd10);
    apb(1, `EGCS_OFF_LOWER, 32'd0);
    for (int i = 0; i < `EGCS_NSTEPS; i++)
      apb(1, `EGCS_OFF_STEP0 + 12'(4 * i), 32'(2 * (i + 1)));
    apb(1, `EGCS_OFF_CAMCFG, 32'h103);
    apb(1, `EGCS_OFF_COUNT, 32'd7);
    cnt = 7;
    for (int k = 0; k < 40; k++) begin
      dn = $random(seed);
      hw = 3 + ($random(seed) & 3);
      fld.pulse(dn, hw, 4);
      if (dn) cnt = (cnt == 0) ? 10 : cnt - 1;
      else cnt = (cnt == 10) ? 0 : cnt + 1;
      exp_cam = 1 ^ (cnt >= 2) ^ (cnt >= 4) ^ (cnt >= 6);
      apb(0, `EGCS_OFF_COUNT, 0); chk(rd, 32'(cnt));
      chk(cam_out, exp_cam[0]);
      chk({event0, event2}, 2'b00);
    end
    // linear mode clamps at the upper limit
    apb(1, `EGCS_OFF_CTRL, 32'h5);
    apb(1, `EGCS_OFF_COUNT, 32'd10);
    fld.pulse(0, 4, 4);
    apb(0, `EGCS_OFF_COUNT, 0); chk(rd, 32'd10);
    chk(cam_out, 1'b0);
    // clock enable low: a pulse on a frozen block is not counted
    @(posedge pclk) clk_en <= 1'b0;
    fld.pulse(1, 4, 4);
    @(posedge pclk) clk_en <= 1'b1;
    apb(0, `EGCS_OFF_COUNT, 0); chk(rd, 32'd10);
    fld.pulse(1, 4, 4);
    apb(0, `EGCS_OFF_COUNT, 0); chk(rd, 32'd9);
    chk(cam_out, 1'b0);
    // reset in mid-run returns the registers to their defaults
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `EGCS_OFF_COUNT, 0); chk(rd, 32'd0);
    apb(0, `EGCS_OFF_UPPER, 0); chk(rd, `EGCS_RST_UPPER);
    chk(cam_out, 1'b0);
    tally_and_finish();
  end

  // overall watchdog against a hang
  initial begin
    #300000;
    n_fail++;
    tally_and_finish();
  end
endmodule : event_gen_cam_switch_test
